// File: src/affs_params.svh
// Offsets, reset values, bit groups and timing counts of the fault flag block
`ifndef AFFS_PARAMS_SVH
`define AFFS_PARAMS_SVH

`define AFFS_PAGE_ZERO 8'h00
`define AFFS_SYNC_STAGES 2

// Flag registers
`define AFFS_OFS_LAT_PRI 8'h42
`define AFFS_OFS_LAT_MISC 8'h43
`define AFFS_OFS_LAT_CLK 8'h44
`define AFFS_OFS_LAT_TEMP 8'h47
`define AFFS_OFS_LAT_THERM 8'h48
`define AFFS_OFS_EVT_PRI 8'h49
`define AFFS_FLAG_RESET 8'h00

// Mask registers
`define AFFS_OFS_MSK_PRI 8'h3B
`define AFFS_OFS_MSK_MISC 8'h3C
`define AFFS_OFS_MSK_CLK 8'h3D
`define AFFS_OFS_MSK_TEMP 8'h40
`define AFFS_OFS_MSK_THERM 8'h41
`define AFFS_RST_MSK_PRI 8'hFC
`define AFFS_RST_MSK_MISC 8'hBB
`define AFFS_RST_MSK_CLK 8'hDD
`define AFFS_RST_MSK_TEMP 8'hF6
`define AFFS_RST_MSK_THERM 8'h14
`define AFFS_WR_MSK_PRI 8'hFF
`define AFFS_WR_MSK_MISC 8'h41
`define AFFS_WR_MSK_CLK 8'h80
`define AFFS_WR_MSK_TEMP 8'hF9
`define AFFS_WR_MSK_THERM 8'hFC

// Implemented flag bits per register, lowest byte pri, then misc, clk, temp, therm, evt
`define AFFS_IMPL_BITS 48'hFF_F8_F9_A0_45_FF
// Bits that follow their cause instead of latching
`define AFFS_LIVE_BITS 48'h00_00_00_00_04_00
// Bits whose flag forces shutdown
`define AFFS_SHDN_BITS 48'h00_80_09_A0_40_07

`endif

// File: src/affs_pkg.sv
// Types shared by the fault flag block
package affs_pkg;

    typedef logic [7:0] affs_byte_t;

    // Register selector; flag registers first so the code is the byte index
    typedef enum logic [3:0] {
        SEL_LAT_PRI = 4'h0,
        SEL_LAT_MISC = 4'h1,
        SEL_LAT_CLK = 4'h2,
        SEL_LAT_TEMP = 4'h3,
        SEL_LAT_THERM = 4'h4,
        SEL_EVT_PRI = 4'h5,
        SEL_MSK_PRI = 4'h6,
        SEL_MSK_MISC = 4'h7,
        SEL_MSK_CLK = 4'h8,
        SEL_MSK_TEMP = 4'h9,
        SEL_MSK_THERM = 4'hA,
        SEL_NONE = 4'hF
    } affs_sel_t;

endpackage

// File: src/affs_sync.sv
// Two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/100ps
`default_nettype none
module affs_sync #(
    parameter int WIDTH = 1,
    parameter int STAGES = 2
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    initial begin
        if (WIDTH < 1 || STAGES < 2) begin
            $error("affs_sync: WIDTH >= 1 and STAGES >= 2 required");
        end
    end

    // Only the next stage reads a stage, so metastability stays contained
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : gBit
            logic [STAGES-1:0] chain_r;
            logic [STAGES-1:0] chain_nxt;
            always_comb begin
                chain_nxt = {chain_r[STAGES-2:0], asyncIn[g]};
            end
            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    chain_r <= '0;
                end else begin
                    chain_r <= chain_nxt;
                end
            end
            assign syncOut[g] = chain_r[STAGES-1];
        end
    endgenerate

endmodule
`default_nettype wire

// File: src/affs_sticky.sv
// Sticky flag bank with live bits and a set-wins clear
`timescale 1ns/100ps
`default_nettype none
module affs_sticky #(
    parameter int WIDTH = 48,
    parameter logic [WIDTH-1:0] IMPL = '1,
    parameter logic [WIDTH-1:0] LIVE = '0
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] setIn,
    input wire logic clearIn,
    output logic [WIDTH-1:0] flags_r
);

    logic [WIDTH-1:0] flags_nxt;

    initial begin
        if (WIDTH < 1) begin
            $error("affs_sticky: WIDTH must be at least 1");
        end
    end

    // Set wins over clear; live bits simply follow their cause
    always_comb begin
        flags_nxt = (flags_r & ~{WIDTH{clearIn}}) | setIn;
        flags_nxt = (flags_nxt & ~LIVE) | (setIn & LIVE);
        flags_nxt = flags_nxt & IMPL;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            flags_r <= '0;
        end else begin
            flags_r <= flags_nxt;
        end
    end

endmodule
`default_nettype wire

// File: src/affs_flag_status.sv
// Fault and event flag registers of the amplifier, with masks and shutdown
`timescale 1ns/100ps
`default_nettype none
`include "affs_params.svh"

// Notes on behaviour
// - Brownout mute, infinite hold set primary bits 7,6
// - Limiter max attenuation bit 5, active bit 3
// - High supply below inflection sets bit 4
// - Serial clock error sets bit 2, shutdown
// - Overcurrent sets bit 1 and shuts down
// - Overtemperature sets bit 0 and shuts down
// - Memory CRC error sets misc bit 6, shutdown
// - Noise gate bit 2 follows detection live
// - Gain limiter sets misc bit 0, no shutdown
// - PLL error bit 7, low supply bit 5, shutdown
// - Temperature thresholds set bits 7 to 4
// - Regulator and high supply undervoltage shut down
// - Threshold two shuts down, threshold one not
// - Supply gap below threshold sets bit 5
// - Second register repeats the primary events
// - Flags page zero, read-only, reset zero
// - Mask bit one masks the event interrupt
module affs_flag_status (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic bopMuteEvt,
    input wire logic bopHoldEvt,
    input wire logic limMaxAttenEvt,
    input wire logic belowInflectEvt,
    input wire logic limActiveEvt,
    input wire logic serialClkErrEvt,
    input wire logic overcurrentEvt,
    input wire logic overtempEvt,
    input wire logic otpCrcErrEvt,
    input wire logic noiseGateDet,
    input wire logic gainLimEvt,
    input wire logic pllClkErrEvt,
    input wire logic lowSupplyUvEvt,
    input wire logic tempOver105Evt,
    input wire logic tempOver115Evt,
    input wire logic tempOver125Evt,
    input wire logic tempOver135Evt,
    input wire logic regulatorUvEvt,
    input wire logic highSupplyUvEvt,
    input wire logic thermalTh2Evt,
    input wire logic thermalTh1Evt,
    input wire logic supplyGapLowEvt,
    input wire logic bopActiveEvt,
    input wire logic bopDetectedEvt,
    input wire logic flagClear,
    input wire logic [7:0] regPage,
    input wire logic [7:0] regAddr,
    input wire logic regRdEn,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData_r,
    output logic regRdValid_r,
    output logic shutdown_r,
    output logic irq_r
);

    localparam int N_EVT = 24;
    localparam int N_FLAG = 48;

    // ****************************************
    // Register decode
    // ****************************************
    function automatic affs_pkg::affs_sel_t decodeSel(
        input logic [7:0] page,
        input logic [7:0] addr
    );
        affs_pkg::affs_sel_t sel;
        sel = affs_pkg::SEL_NONE;
        if (page == `AFFS_PAGE_ZERO) begin
            case (addr)
                `AFFS_OFS_LAT_PRI: sel = affs_pkg::SEL_LAT_PRI;
                `AFFS_OFS_LAT_MISC: sel = affs_pkg::SEL_LAT_MISC;
                `AFFS_OFS_LAT_CLK: sel = affs_pkg::SEL_LAT_CLK;
                `AFFS_OFS_LAT_TEMP: sel = affs_pkg::SEL_LAT_TEMP;
                `AFFS_OFS_LAT_THERM: sel = affs_pkg::SEL_LAT_THERM;
                `AFFS_OFS_EVT_PRI: sel = affs_pkg::SEL_EVT_PRI;
                `AFFS_OFS_MSK_PRI: sel = affs_pkg::SEL_MSK_PRI;
                `AFFS_OFS_MSK_MISC: sel = affs_pkg::SEL_MSK_MISC;
                `AFFS_OFS_MSK_CLK: sel = affs_pkg::SEL_MSK_CLK;
                `AFFS_OFS_MSK_TEMP: sel = affs_pkg::SEL_MSK_TEMP;
                `AFFS_OFS_MSK_THERM: sel = affs_pkg::SEL_MSK_THERM;
                default: sel = affs_pkg::SEL_NONE;
            endcase
        end
        return sel;
    endfunction

    // ****************************************
    // Event synchronisation
    // ****************************************
    logic [N_EVT-1:0] evtRaw;
    logic [N_EVT-1:0] evtSync;
    logic sBopMute, sBopHold, sLimMax, sBelowInfl, sLimAct, sSerClk;
    logic sOverCur, sOverTemp, sOtpCrc, sNoiseGate, sGainLim, sPllClk;
    logic sLowUv, sT105, sT115, sT125, sT135, sRegUv, sHighUv;
    logic sTh2, sTh1, sGapLow, sBopAct, sBopDet;

    assign evtRaw = {bopMuteEvt, bopHoldEvt, limMaxAttenEvt,
        belowInflectEvt, limActiveEvt, serialClkErrEvt, overcurrentEvt,
        overtempEvt, otpCrcErrEvt, noiseGateDet, gainLimEvt, pllClkErrEvt,
        lowSupplyUvEvt, tempOver105Evt, tempOver115Evt, tempOver125Evt,
        tempOver135Evt, regulatorUvEvt, highSupplyUvEvt, thermalTh2Evt,
        thermalTh1Evt, supplyGapLowEvt, bopActiveEvt, bopDetectedEvt};

    // Analog detectors run unclocked, so every cause is synchronised first
    affs_sync #(
        .WIDTH(N_EVT),
        .STAGES(`AFFS_SYNC_STAGES)
    ) uSync (
        .clock(clock),
        .rst_b(rst_b),
        .asyncIn(evtRaw),
        .syncOut(evtSync)
    );

    assign {sBopMute, sBopHold, sLimMax, sBelowInfl, sLimAct, sSerClk,
        sOverCur, sOverTemp, sOtpCrc, sNoiseGate, sGainLim, sPllClk,
        sLowUv, sT105, sT115, sT125, sT135, sRegUv, sHighUv,
        sTh2, sTh1, sGapLow, sBopAct, sBopDet} = evtSync;

    // ****************************************
    // Flag bank
    // ****************************************
    logic [7:0] setPri, setMisc, setClk, setTemp, setTherm;
    logic [N_FLAG-1:0] flagSet;
    logic [N_FLAG-1:0] flags;
    logic [7:0] flagByte [6];

    always_comb begin
        setPri = {sBopMute, sBopHold, sLimMax, sBelowInfl,
            sLimAct, sSerClk, sOverCur, sOverTemp};
        setMisc = {1'b0, sOtpCrc, 3'b000, sNoiseGate,
            1'b0, sGainLim};
        setClk = {sPllClk, 1'b0, sLowUv, 5'b00000};
        setTemp = {sT105, sT115, sT125, sT135,
            sRegUv, 2'b00, sHighUv};
        setTherm = {sTh2, sTh1, sGapLow, sBopAct,
            sBopDet, 3'b000};
        // Second event register sees the same causes as the first
        flagSet = {setPri, setTherm, setTemp, setClk, setMisc, setPri};
    end

    // Flags other than the live noise gate bit hold until the external clear; reset leaves all at zero
    affs_sticky #(
        .WIDTH(N_FLAG),
        .IMPL(`AFFS_IMPL_BITS),
        .LIVE(`AFFS_LIVE_BITS)
    ) uSticky (
        .clock(clock),
        .rst_b(rst_b),
        .setIn(flagSet),
        .clearIn(flagClear),
        .flags_r(flags)
    );

    genvar gb;
    generate
        for (gb = 0; gb < 6; gb++) begin : gByte
            assign flagByte[gb] = flags[gb*8 +: 8];
        end
    endgenerate

    // ****************************************
    // Mask registers
    // ****************************************
    logic [7:0] mskPri_r, mskMisc_r, mskClk_r, mskTemp_r, mskTherm_r;
    logic [7:0] mskPri_nxt, mskMisc_nxt, mskClk_nxt, mskTemp_nxt, mskTherm_nxt;
    affs_pkg::affs_sel_t wrSel;

    // Only documented mask bits take writes; reserved bits keep reset value
    always_comb begin
        wrSel = decodeSel(regPage, regAddr);
        mskPri_nxt = mskPri_r;
        mskMisc_nxt = mskMisc_r;
        mskClk_nxt = mskClk_r;
        mskTemp_nxt = mskTemp_r;
        mskTherm_nxt = mskTherm_r;
        if (regWrEn) begin
            case (wrSel)
                affs_pkg::SEL_MSK_PRI:
                    mskPri_nxt = (mskPri_r & ~`AFFS_WR_MSK_PRI)
                        | (regWrData & `AFFS_WR_MSK_PRI);
                affs_pkg::SEL_MSK_MISC:
                    mskMisc_nxt = (mskMisc_r & ~`AFFS_WR_MSK_MISC)
                        | (regWrData & `AFFS_WR_MSK_MISC);
                affs_pkg::SEL_MSK_CLK:
                    mskClk_nxt = (mskClk_r & ~`AFFS_WR_MSK_CLK)
                        | (regWrData & `AFFS_WR_MSK_CLK);
                affs_pkg::SEL_MSK_TEMP:
                    mskTemp_nxt = (mskTemp_r & ~`AFFS_WR_MSK_TEMP)
                        | (regWrData & `AFFS_WR_MSK_TEMP);
                affs_pkg::SEL_MSK_THERM:
                    mskTherm_nxt = (mskTherm_r & ~`AFFS_WR_MSK_THERM)
                        | (regWrData & `AFFS_WR_MSK_THERM);
                default: mskPri_nxt = mskPri_r; // Flag registers ignore writes
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mskPri_r <= `AFFS_RST_MSK_PRI;
            mskMisc_r <= `AFFS_RST_MSK_MISC;
            mskClk_r <= `AFFS_RST_MSK_CLK;
            mskTemp_r <= `AFFS_RST_MSK_TEMP;
            mskTherm_r <= `AFFS_RST_MSK_THERM;
        end else begin
            mskPri_r <= mskPri_nxt;
            mskMisc_r <= mskMisc_nxt;
            mskClk_r <= mskClk_nxt;
            mskTemp_r <= mskTemp_nxt;
            mskTherm_r <= mskTherm_nxt;
        end
    end

    // ****************************************
    // Read port, shutdown and interrupt
    // ****************************************
    logic [N_FLAG-1:0] maskAll;
    logic [7:0] regRdData_nxt;
    logic regRdValid_nxt, shutdown_nxt, irq_nxt;
    affs_pkg::affs_sel_t rdSel;

    always_comb begin
        // The repeated event register shares the primary masks
        maskAll = {mskPri_r, mskTherm_r, mskTemp_r, mskClk_r, mskMisc_r, mskPri_r};
        rdSel = decodeSel(regPage, regAddr);
        regRdValid_nxt = regRdEn;
        regRdData_nxt = regRdData_r;
        if (regRdEn) begin
            case (rdSel)
                affs_pkg::SEL_LAT_PRI,
                affs_pkg::SEL_LAT_MISC,
                affs_pkg::SEL_LAT_CLK,
                affs_pkg::SEL_LAT_TEMP,
                affs_pkg::SEL_LAT_THERM,
                affs_pkg::SEL_EVT_PRI:
                    regRdData_nxt = flagByte[rdSel[2:0]];
                affs_pkg::SEL_MSK_PRI: regRdData_nxt = mskPri_r;
                affs_pkg::SEL_MSK_MISC: regRdData_nxt = mskMisc_r;
                affs_pkg::SEL_MSK_CLK: regRdData_nxt = mskClk_r;
                affs_pkg::SEL_MSK_TEMP: regRdData_nxt = mskTemp_r;
                affs_pkg::SEL_MSK_THERM: regRdData_nxt = mskTherm_r;
                default: regRdData_nxt = `AFFS_FLAG_RESET;
            endcase
        end
        // Shutdown stays while a shutdown flag is latched, so a clear releases it once no shutdown cause is still present
        shutdown_nxt = |(flags & `AFFS_SHDN_BITS);
        irq_nxt = |(flags & ~maskAll);
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            regRdData_r <= `AFFS_FLAG_RESET;
            regRdValid_r <= 1'b0;
            shutdown_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            regRdData_r <= regRdData_nxt;
            regRdValid_r <= regRdValid_nxt;
            shutdown_r <= shutdown_nxt;
            irq_r <= irq_nxt;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence s_cause_to_shdn(logic cause);
        cause ##2 shutdown_r;
    endsequence

    sequence s_flag_then_irq;
        (|(flags & ~maskAll)) ##1 irq_r;
    endsequence

    a_bop_latch: assert property (sBopMute && sBopHold |=> flagByte[0][7:6] == 2'b11)
        else $error("brownout flags not latched");
    a_limiter_latch: assert property (sLimMax && sLimAct |=> flagByte[0][5] && flagByte[0][3])
        else $error("limiter flags not latched");
    a_inflect_latch: assert property (sBelowInfl |=> flagByte[0][4])
        else $error("inflection flag not latched");
    a_serclk_shdn: assert property (sSerClk |-> s_cause_to_shdn(sSerClk))
        else $error("serial clock error did not shut down");
    a_overcur_shdn: assert property (sOverCur |=> flagByte[0][1] ##1 shutdown_r)
        else $error("overcurrent did not shut down");
    a_overtemp_shdn: assert property (sOverTemp |-> s_cause_to_shdn(sOverTemp))
        else $error("overtemperature did not shut down");
    a_crc_shdn: assert property (sOtpCrc |=> flagByte[1][6] ##1 shutdown_r)
        else $error("memory CRC error did not shut down");
    a_noise_live: assert property (##1 flagByte[1][2] == $past(sNoiseGate))
        else $error("noise gate bit not live");
    a_gainlim_noshdn: assert property (flags == 48'h01_00 |=> !shutdown_r)
        else $error("gain limiter caused shutdown");
    a_pll_shdn: assert property (sPllClk && sLowUv |=> flagByte[2][7] && flagByte[2][5] ##1 shutdown_r)
        else $error("clock or supply fault missed");
    a_temp_noshdn: assert property ((flags & 48'hFF_FF_0F_FF_FF_FF) == 48'h0 |=> !shutdown_r)
        else $error("temperature warning caused shutdown");
    a_uv_shdn: assert property (sRegUv || sHighUv |-> ##2 shutdown_r)
        else $error("undervoltage did not shut down");
    a_th_levels: assert property (sTh2 |-> ##2 shutdown_r)
        else $error("threshold two did not shut down");
    a_gap_latch: assert property (sGapLow |=> flagByte[4][5])
        else $error("supply gap flag not latched");
    a_evt_mirror: assert property (flagByte[5] == flagByte[0])
        else $error("event register differs from primary");
    a_page_zero: assert property (regRdEn && regPage != `AFFS_PAGE_ZERO |=> regRdData_r == 8'h00 && regRdValid_r)
        else $error("off-page read not zero");
    a_mask_write: assert property (regWrEn && wrSel == affs_pkg::SEL_MSK_TEMP |=> mskTemp_r[7] == $past(regWrData[7]))
        else $error("mask write lost");
    a_flag_hold: assert property (!flagClear |=> ((flags & ~`AFFS_LIVE_BITS) & $past(flags)) == ($past(flags) & ~`AFFS_LIVE_BITS))
        else $error("latched flag dropped without clear");
    a_irq_follow: assert property (|(flags & ~maskAll) |-> s_flag_then_irq)
        else $error("unmasked flag raised no interrupt");

endmodule
`default_nettype wire

// File: testbench/amp_fault_flag_status_bench.sv
// Self-checking bench of the fault and event flag block
`timescale 1ns/100ps
`default_nettype none
`include "affs_params.svh"
module amp_fault_flag_status_bench;
    // ********************
    // Signals and tables
    // ********************
    logic clock;
    logic rst_b;
    logic [23:0] evt;
    logic flagClear;
    logic [7:0] regPage;
    logic [7:0] regAddr;
    logic regRdEn;
    logic regWrEn;
    logic [7:0] regWrData;
    logic [7:0] regRdData_r;
    logic regRdValid_r;
    logic shutdown_r;
    logic irq_r;
    logic [7:0] flagExp [6];
    logic [7:0] mskExp [5];
    logic [31:0] seed;
    int num_errors;
    int n_tests;
    localparam logic [7:0] FOFS [6] = '{8'h42, 8'h43, 8'h44, 8'h47, 8'h48, 8'h49};
    localparam logic [7:0] MOFS [5] = '{8'h3B, 8'h3C, 8'h3D, 8'h40, 8'h41};
    localparam logic [7:0] SDB [5] = '{8'h07, 8'h40, 8'hA0, 8'h09, 8'h80};
    localparam logic [7:0] MRST [5] = '{`AFFS_RST_MSK_PRI, `AFFS_RST_MSK_MISC,
        `AFFS_RST_MSK_CLK, `AFFS_RST_MSK_TEMP, `AFFS_RST_MSK_THERM};
    localparam logic [7:0] MWR [5] = '{`AFFS_WR_MSK_PRI, `AFFS_WR_MSK_MISC,
        `AFFS_WR_MSK_CLK, `AFFS_WR_MSK_TEMP, `AFFS_WR_MSK_THERM};

    affs_flag_status i_affs_flag_status (
        .clock(clock), .rst_b(rst_b),
        .bopMuteEvt(evt[0]), .bopHoldEvt(evt[1]), .limMaxAttenEvt(evt[2]),
        .belowInflectEvt(evt[3]), .limActiveEvt(evt[4]), .serialClkErrEvt(evt[5]),
        .overcurrentEvt(evt[6]), .overtempEvt(evt[7]), .otpCrcErrEvt(evt[8]),
        .noiseGateDet(evt[9]), .gainLimEvt(evt[10]), .pllClkErrEvt(evt[11]),
        .lowSupplyUvEvt(evt[12]), .tempOver105Evt(evt[13]), .tempOver115Evt(evt[14]),
        .tempOver125Evt(evt[15]), .tempOver135Evt(evt[16]), .regulatorUvEvt(evt[17]),
        .highSupplyUvEvt(evt[18]), .thermalTh2Evt(evt[19]), .thermalTh1Evt(evt[20]),
        .supplyGapLowEvt(evt[21]), .bopActiveEvt(evt[22]), .bopDetectedEvt(evt[23]),
        .flagClear(flagClear), .regPage(regPage), .regAddr(regAddr), .regRdEn(regRdEn),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdData_r(regRdData_r),
        .regRdValid_r(regRdValid_r), .shutdown_r(shutdown_r), .irq_r(irq_r)
    );

    // ********************
    // Helpers
    // ********************
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        for (int k = 0; k < 8; k++) x = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
        return x;
    endfunction

    // Flag register index and bit position of each event input
    function automatic int regOf(input int i);
        if (i < 8) return 0;
        if (i < 11) return 1;
        if (i < 13) return 2;
        if (i < 19) return 3;
        return 4;
    endfunction

    function automatic int bitOf(input int i);
        case (i)
            8: return 6;
            9: return 2;
            10: return 0;
            11: return 7;
            12: return 5;
            17: return 3;
            18: return 0;
            default: return (i < 8) ? 7 - i : (i < 17) ? 20 - i : 26 - i;
        endcase
    endfunction

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic rd(input logic [7:0] pg, input logic [7:0] a, output logic [7:0] d);
        int k;
        @(posedge clock);
        regPage <= pg;
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clock);
        regRdEn <= 1'b0;
        #1;
        for (k = 0; k < 4 && regRdValid_r !== 1'b1; k++) begin
            @(posedge clock);
            #1;
        end
        if (regRdValid_r === 1'b1) begin
            d = regRdData_r;
        end else begin
            num_errors++;
            close_out();
        end
    endtask

    task automatic setMask(input int r, input logic [7:0] d);
        @(posedge clock);
        regPage <= 8'h00;
        regAddr <= MOFS[r];
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clock);
        regWrEn <= 1'b0;
        mskExp[r] = (mskExp[r] & ~MWR[r]) | (d & MWR[r]);
    endtask

    // Causes held long enough to pass the synchroniser, then dropped
    task automatic pulse(input logic [23:0] v);
        @(posedge clock);
        evt <= v;
        tick(4);
        evt <= '0;
        for (int i = 0; i < 24; i++) if (v[i] && i != 9) flagExp[regOf(i)][bitOf(i)] = 1'b1;
        flagExp[5] = flagExp[0];
        tick(6);
    endtask

    task automatic clr();
        @(posedge clock);
        flagClear <= 1'b1;
        tick(1);
        flagClear <= 1'b0;
        foreach (flagExp[r]) flagExp[r] = 8'h00;
        tick(4);
    endtask

    task automatic checkAll();
        logic [7:0] d;
        logic sd;
        logic irq;
        sd = 1'b0;
        irq = 1'b0;
        for (int r = 0; r < 6; r++) begin
            rd(8'h00, FOFS[r], d);
            check($sformatf("flag %h", FOFS[r]), d, flagExp[r]);
        end
        for (int r = 0; r < 5; r++) begin
            sd |= |(flagExp[r] & SDB[r]);
            irq |= |(flagExp[r] & ~mskExp[r]);
        end
        check("shutdown", {7'h00, shutdown_r}, {7'h00, sd});
        check("interrupt", {7'h00, irq_r}, {7'h00, irq});
    endtask

    // ********************
    // Stimulus
    // ********************
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Hang guard well beyond the longest sequence
    initial begin
        #400000;
        num_errors++;
        close_out();
    end

    initial begin
        logic [7:0] d;
        logic [23:0] v;
        rst_b = 1'b0;
        evt = '0;
        flagClear = 1'b0;
        regPage = 8'h00;
        regAddr = 8'h00;
        regRdEn = 1'b0;
        regWrEn = 1'b0;
        regWrData = 8'h00;
        num_errors = 0;
        n_tests = 0;
        seed = 32'h9BDF4C95;
        foreach (flagExp[r]) flagExp[r] = 8'h00;
        mskExp = MRST;
        tick(16);
        rst_b <= 1'b1;
        checkAll();
        for (int r = 0; r < 5; r++) begin
            rd(8'h00, MOFS[r], d);
            check("mask reset", d, MRST[r]);
        end
        // Each cause alone; every flag except the live noise gate must outlive its cause
        for (int i = 0; i < 24; i++) begin
            pulse(24'h000001 << i);
            checkAll();
            clr();
        end
        // Noise gate follows its input instead of latching
        @(posedge clock) evt <= 24'h000200;
        tick(5);
        rd(8'h00, 8'h43, d);
        check("noise gate held", d, 8'h04);
        @(posedge clock) evt <= '0;
        tick(5);
        rd(8'h00, 8'h43, d);
        check("noise gate gone", d, 8'h00);
        // A cause still present during the clear keeps its flag
        @(posedge clock) evt <= 24'h000080;
        tick(5);
        clr();
        rd(8'h00, 8'h42, d);
        check("clear with cause", d, 8'h01);
        @(posedge clock) evt <= '0;
        tick(4);
        clr();
        // A write to a flag register changes nothing; other pages and unmapped offsets read zero
        pulse(24'h0000FF);
        setMask(0, 8'hFE);
        tick(1);
        regAddr <= 8'h42;
        regWrEn <= 1'b1;
        regWrData <= 8'h00;
        tick(1);
        regWrEn <= 1'b0;
        rd(8'h01, 8'h42, d);
        check("other page", d, 8'h00);
        rd(8'h00, 8'h45, d);
        check("unmapped", d, 8'h00);
        checkAll();
        clr();
        // Random causes and masks; clears now and then
        for (int n = 0; n < 40; n++) begin
            seed = lfsr(seed);
            v = seed[23:0];
            seed = lfsr(seed);
            v &= seed[23:0];
            seed = lfsr(seed);
            setMask(seed[2:0] % 5, seed[15:8]);
            rd(8'h00, MOFS[seed[2:0] % 5], d);
            check("mask readback", d, mskExp[seed[2:0] % 5]);
            pulse(v);
            checkAll();
            if (seed[31:30] == 2'b00) clr();
        end
        close_out();
    end
endmodule
`default_nettype wire
